// ===== include/ompc_pkg.sv
// Operation
// - Mode pin B high at reset selects normal mode, reset vector area at FFFA.
// - Mode pin B low selects special mode, vector area BFFA, test features on.
// - Special-mode bit loads inverse of mode pin B at reset release.
// - Mode-select-A bit loads mode pin A level at reset release.
// - Both mode bits always readable; writable anytime in special modes.
// - Normal modes accept only the first write to mode-select-A after reset.
// - Special-mode bit, once cleared, cannot be set again until reset.
// - Boot ROM enable acts only with special-mode set; writable only in special modes.
// - Boot ROM enable 1 maps boot ROM at BE00; 0 removes it.
// - Reset values follow mode; selector 0110, boot ROM in bootstrap, visibility in test.
// - Selector 0000-0100 promotes timer, accumulator overflow, edge, SPI, SCI.
// - Selector 0110 promotes external pin, 0111 promotes real-time interrupt.
// - Reserved selector 0101 behaves as external pin source.
// - Selector 1000-1111 promotes captures 1-3, compares 1-4, shared capture4/compare5.
// - Single-chip mode: strobe-A pin is a handshake strobe input.
// - Expanded mode: strobe-A pin drives address strobe for port C demultiplexing.
// - Single-chip mode: strobe-B pin is a programmable output strobe.
// - Expanded mode: direction pin low on writes, high on reads, low across writes.
// - Read visibility, in expanded mode only, drives internal read data onto port C.
// - Port B: general outputs single-chip, high address byte when expanded.
// - Port C: general I/O single-chip, multiplexed address/data when expanded.
// - Register 103C: boot ROM 7, special 6, mode A 5, visibility 4, selector 3:0.
package ompc_pkg;
  localparam logic [15:0] OMPC_CTRL_ADDR = 16'h103c;
  localparam int OMPC_BOOT_BIT = 7;
  localparam int OMPC_SPECIAL_BIT = 6;
  localparam int OMPC_MODE_A_BIT = 5;
  localparam int OMPC_VIS_BIT = 4;
  localparam logic [3:0] OMPC_PSEL_RST = 4'h6;
  localparam logic [3:0] OMPC_PSEL_RSVD = 4'h5;
  localparam logic [3:0] OMPC_PSEL_IRQ = 4'h6;
  localparam logic [15:0] OMPC_VEC_NORMAL = 16'hfffa;
  localparam logic [15:0] OMPC_VEC_SPECIAL = 16'hbffa;
  localparam logic [15:0] OMPC_BOOT_BASE = 16'hbe00;
  localparam logic [15:0] OMPC_BOOT_LAST = 16'hbfff;
  localparam logic [1:0] OMPC_RESP_OKAY = 2'h0;
  localparam logic [1:0] OMPC_RESP_SLVERR = 2'h2;
  localparam int OMPC_NSRC = 16;
endpackage

// ===== hw/ompc_top.sv
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module ompc_top
  import ompc_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Mode pins, sampled on the clock that follows reset release
  input wire logic mode_pin_a,
  input wire logic mode_pin_b,
  // AXI4-Lite write address
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Mode status
  output logic special_mode,
  output logic expanded_mode,
  output logic [15:0] reset_vector_addr,
  output logic boot_rom_mapped,
  // Interrupt arbitration
  input wire logic [OMPC_NSRC-1:0] irq_src_pending,
  input wire logic arb_start,
  output logic [OMPC_NSRC-1:0] irq_promoted,
  // CPU bus cycle from core
  input wire logic cpu_cycle,
  input wire logic cpu_write,
  input wire logic [15:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  input wire logic cpu_internal,
  input wire logic [7:0] cpu_internal_rdata,
  input wire logic cpu_addr_phase,
  // General port values from parallel I/O logic
  input wire logic [7:0] gp_port_b,
  input wire logic [7:0] gp_port_c,
  input wire logic [7:0] gp_port_c_dir,
  input wire logic strobe_b_level,
  // Strobe A pin (input function) and address strobe
  input wire logic strobe_a_input,
  output logic strobe_a_handshake,
  output logic address_strobe_out,
  output logic address_strobe_oe,
  // Strobe B / direction pin
  output logic strobe_b_output,
  output logic strobe_b_oe,
  // Port B and port C pins
  output logic [7:0] port_b_out,
  input wire logic [7:0] port_c_in,
  output logic [7:0] port_c_out,
  output logic [7:0] port_c_oe,
  output logic [7:0] port_c_rdata
);

  // ************************************************************
  // Mode latch
  // ************************************************************
  logic in_reset_ff;
  logic boot_rom_enable_ff;
  logic special_mode_bit_ff;
  logic mode_select_a_bit_ff;
  logic read_visibility_bit_ff;
  logic [3:0] psel_ff;
  logic mode_a_written_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      in_reset_ff <= 1'b1;
    else
      in_reset_ff <= 1'b0;
  end

  // Strap decode; only looked at on the clock that follows reset release
  logic strap_special;
  logic strap_mode_a;
  logic strap_boot;
  logic strap_vis;

  assign strap_special = !mode_pin_b;
  assign strap_mode_a = mode_pin_a;
  // Boot ROM only in bootstrap, visibility only in test
  assign strap_boot = !mode_pin_b && !mode_pin_a;
  assign strap_vis = !mode_pin_b && mode_pin_a;

  // ************************************************************
  // AXI4-Lite slave
  // ************************************************************
  logic aw_held_ff;
  logic w_held_ff;
  logic [15:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic do_write;
  logic wr_hit;
  logic ar_hit;

  assign s_axi_awready = !aw_held_ff && !s_axi_bvalid;
  assign s_axi_wready = !w_held_ff && !s_axi_bvalid;
  assign do_write = aw_held_ff && w_held_ff && !s_axi_bvalid;
  assign wr_hit = do_write && (awaddr_ff[15:2] == OMPC_CTRL_ADDR[15:2]);
  assign s_axi_arready = !s_axi_rvalid;
  assign ar_hit = s_axi_araddr[15:2] == OMPC_CTRL_ADDR[15:2];

  // Address and data come in either order; each is parked until its partner arrives
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      aw_held_ff <= 1'b0;
    else if (s_axi_awvalid && s_axi_awready)
      aw_held_ff <= 1'b1;
    else if (do_write)
      aw_held_ff <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      awaddr_ff <= 16'h0000;
    else if (s_axi_awvalid && s_axi_awready)
      awaddr_ff <= s_axi_awaddr;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      w_held_ff <= 1'b0;
    else if (s_axi_wvalid && s_axi_wready)
      w_held_ff <= 1'b1;
    else if (do_write)
      w_held_ff <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
    end
  end

  // Response rises the clock after both halves are held
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= OMPC_RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? OMPC_RESP_OKAY : OMPC_RESP_SLVERR;
    end
    else if (s_axi_bvalid && s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Fields placed by position so read and write share one layout
  logic [7:0] ctrl_rd_byte;

  always_comb
  begin
    ctrl_rd_byte = 8'h00;
    ctrl_rd_byte[3:0] = psel_ff;
    ctrl_rd_byte[OMPC_VIS_BIT] = read_visibility_bit_ff;
    ctrl_rd_byte[OMPC_MODE_A_BIT] = mode_select_a_bit_ff;
    ctrl_rd_byte[OMPC_SPECIAL_BIT] = special_mode_bit_ff;
    ctrl_rd_byte[OMPC_BOOT_BIT] = boot_rom_enable_ff;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_axi_rvalid <= 1'b0;
    else if (s_axi_arvalid && s_axi_arready)
      s_axi_rvalid <= 1'b1;
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Both mode bits readable at any time; unmapped reads return zero
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= OMPC_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rdata <= ar_hit ? {24'h000000, ctrl_rd_byte} : 32'h0000_0000;
      s_axi_rresp <= ar_hit ? OMPC_RESP_OKAY : OMPC_RESP_SLVERR;
    end
  end

  // ************************************************************
  // Control register
  // ************************************************************
  logic wr_low;
  logic [7:0] wbyte;

  assign wr_low = wr_hit && wstrb_ff[0];
  assign wbyte = wdata_ff[7:0];

  // Straps are caught on the first clock after release, never under reset
  // Clearing is allowed, setting only while already set
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      special_mode_bit_ff <= 1'b0;
    else if (in_reset_ff)
      special_mode_bit_ff <= strap_special;
    else if (wr_low)
      special_mode_bit_ff <= special_mode_bit_ff && wbyte[OMPC_SPECIAL_BIT];
  end

  // Free in special modes, once only in normal modes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mode_select_a_bit_ff <= 1'b0;
    else if (in_reset_ff)
      mode_select_a_bit_ff <= strap_mode_a;
    else if (wr_low && (special_mode_bit_ff || !mode_a_written_ff))
      mode_select_a_bit_ff <= wbyte[OMPC_MODE_A_BIT];
  end

  // Any write uses up the one normal-mode chance, even when the bit is unchanged
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mode_a_written_ff <= 1'b0;
    else if (in_reset_ff)
      mode_a_written_ff <= 1'b0;
    else if (wr_low)
      mode_a_written_ff <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      boot_rom_enable_ff <= 1'b0;
    else if (in_reset_ff)
      boot_rom_enable_ff <= strap_boot;
    else if (wr_low && special_mode_bit_ff)
      boot_rom_enable_ff <= wbyte[OMPC_BOOT_BIT];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      read_visibility_bit_ff <= 1'b0;
    else if (in_reset_ff)
      read_visibility_bit_ff <= strap_vis;
    else if (wr_low)
      read_visibility_bit_ff <= wbyte[OMPC_VIS_BIT];
  end

  // ************************************************************
  // Interrupt priority selector
  // ************************************************************
  logic [3:0] psel_arb_ff;
  logic [3:0] psel_eff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      psel_ff <= OMPC_PSEL_RST;
    else if (wr_low)
      psel_ff <= wbyte[3:0];
  end

  // Snapshot only at arbitration start so a running sequence is undisturbed
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      psel_arb_ff <= OMPC_PSEL_RST;
    else if (arb_start)
      psel_arb_ff <= psel_ff;
  end

  assign psel_eff = (psel_arb_ff == OMPC_PSEL_RSVD) ? OMPC_PSEL_IRQ : psel_arb_ff;

  // Index order of irq_src_pending matches selector encoding
  genvar gi;
  generate
    for (gi = 0; gi < OMPC_NSRC; gi++)
    begin : g_prom
      assign irq_promoted[gi] = irq_src_pending[gi] && (psel_eff == 4'(gi));
    end
  endgenerate

  // ************************************************************
  // Mode outputs
  // ************************************************************
  assign special_mode = special_mode_bit_ff;
  assign expanded_mode = mode_select_a_bit_ff;
  assign reset_vector_addr = special_mode_bit_ff ? OMPC_VEC_SPECIAL : OMPC_VEC_NORMAL;
  assign boot_rom_mapped = boot_rom_enable_ff && special_mode_bit_ff;

  // ************************************************************
  // Pin functions
  // ************************************************************
  logic dir_ff;
  logic vis_drive;

  // Direction stays low across back-to-back writes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      dir_ff <= 1'b1;
    else if (cpu_cycle)
      dir_ff <= !cpu_write;
  end

  assign vis_drive = read_visibility_bit_ff && cpu_cycle && !cpu_write && cpu_internal;

  assign strobe_a_handshake = !expanded_mode && strobe_a_input;
  assign address_strobe_out = expanded_mode && cpu_addr_phase;
  assign address_strobe_oe = expanded_mode;
  assign strobe_b_output = expanded_mode ? dir_ff : strobe_b_level;
  assign strobe_b_oe = 1'b1;
  assign port_b_out = expanded_mode ? cpu_addr[15:8] : gp_port_b;

  always_comb
  begin
    port_c_out = gp_port_c;
    port_c_oe = gp_port_c_dir;
    if (expanded_mode)
    begin
      port_c_oe = 8'h00;
      if (cpu_addr_phase)
      begin
        port_c_out = cpu_addr[7:0];
        port_c_oe = 8'hff;
      end
      else if (cpu_cycle && cpu_write)
      begin
        port_c_out = cpu_wdata;
        port_c_oe = 8'hff;
      end
      else if (vis_drive)
      begin
        port_c_out = cpu_internal_rdata;
        port_c_oe = 8'hff;
      end
    end
  end

  assign port_c_rdata = port_c_in;

endmodule

// ===== verif/ompc_ext_mem.sv
`timescale 1ns/1ps
// ****
// External memory on the multiplexed bus
// ****
module ompc_ext_mem (
  // Bus from the device
  input wire logic aclk,
  input wire logic address_strobe_out,
  input wire logic strobe_b_output,
  input wire logic [7:0] port_c_out,
  input wire logic [7:0] port_c_oe,
  // Data back to the device
  output logic [7:0] port_c_in
);
  logic [7:0] adr_ff;
  logic [7:0] junk_ff = 8'h5a;
  // Low address byte is valid only while the strobe is high
  always_ff @(posedge aclk) if (address_strobe_out) adr_ff <= port_c_out;
  always_ff @(posedge aclk) junk_ff <= ~junk_ff;
  // A bus nobody drives returns the inverted latched low address on reads and a toggling pattern otherwise
  assign port_c_in = (|port_c_oe) ? port_c_out : strobe_b_output ? ~adr_ff : junk_ff;
endmodule

// ===== verif/ompc_chk.sv
`timescale 1ns/1ps
// ****
// Port checker
// ****
module ompc_chk
  import ompc_pkg::*;
(
  // Clock, reset and bus
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // Mode and arbitration
  input wire logic special_mode,
  input wire logic expanded_mode,
  input wire logic [15:0] reset_vector_addr,
  input wire logic boot_rom_mapped,
  input wire logic [OMPC_NSRC-1:0] irq_src_pending,
  input wire logic [OMPC_NSRC-1:0] irq_promoted,
  // Pins
  input wire logic cpu_cycle,
  input wire logic cpu_write,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_addr_phase,
  input wire logic [7:0] gp_port_b,
  input wire logic strobe_b_level,
  input wire logic strobe_b_output,
  input wire logic address_strobe_out,
  input wire logic address_strobe_oe,
  input wire logic [7:0] port_b_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_vec; reset_vector_addr == (special_mode ? 16'hbffa : 16'hfffa); endproperty
  a_vec: assert property (p_vec) else $error("reset vector wrong");
  property p_boot; boot_rom_mapped |-> special_mode; endproperty
  a_boot: assert property (p_boot) else $error("boot rom mapped outside special");
  // Two cycles of history skip the strap load just after reset
  property p_special; $past(aresetn, 2) && !$past(special_mode) |-> !special_mode; endproperty
  a_special: assert property (p_special) else $error("special bit set again");
  property p_addr_strobe; address_strobe_oe == expanded_mode &&
    address_strobe_out == (expanded_mode && cpu_addr_phase); endproperty
  a_addr_strobe: assert property (p_addr_strobe) else $error("address strobe wrong");
  property p_pb; port_b_out == (expanded_mode ? cpu_addr[15:8] : gp_port_b); endproperty
  a_pb: assert property (p_pb) else $error("port b wrong");
  property p_strobe_b; !expanded_mode |-> strobe_b_output == strobe_b_level; endproperty
  a_strobe_b: assert property (p_strobe_b) else $error("strobe b wrong");
  property p_dir; expanded_mode && cpu_cycle && cpu_write ##1 expanded_mode |-> !strobe_b_output;
  endproperty
  a_dir: assert property (p_dir) else $error("direction not low on write");
  property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
  property p_prom; $onehot0(irq_promoted) && (irq_promoted & ~irq_src_pending) == '0; endproperty
  a_prom: assert property (p_prom) else $error("promotion not one pending");
endmodule
bind ompc_top ompc_chk chk_u (.*);

// ===== verif/testbench.sv
`timescale 1ns/1ps
// ****
// Testbench
// ****
module testbench
  import ompc_pkg::*;
;
  logic aclk = 0, aresetn = 0, mode_pin_a = 0, mode_pin_b = 0, arb_start = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, cpu_cycle = 0, cpu_write = 0, cpu_internal = 0, cpu_addr_phase = 0;
  logic strobe_b_level = 0, strobe_a_input = 0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd_d;
  logic [15:0] s_axi_awaddr = '0, s_axi_araddr = '0, cpu_addr = '0, irq_src_pending = 16'hffff;
  logic [7:0] cpu_wdata = '0, cpu_internal_rdata = '0, gp_port_b = '0, gp_port_c = '0;
  logic [7:0] gp_port_c_dir = '0, port_b_out, port_c_in, port_c_out, port_c_oe, port_c_rdata;
  logic [15:0] reset_vector_addr, irq_promoted;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_r;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, special_mode;
  logic expanded_mode, boot_rom_mapped, strobe_a_handshake, address_strobe_out;
  logic address_strobe_oe, strobe_b_output, strobe_b_oe;
  int mismatches = 0, total_checks = 0;
  // Each row: selector code, then the promoted source
  logic [19:0] rows [16] = '{20'h0_0001, 20'h1_0002, 20'h2_0004, 20'h3_0008, 20'h4_0010,
    20'h5_0040, 20'h6_0040, 20'h7_0080, 20'h8_0100, 20'h9_0200, 20'ha_0400, 20'hb_0800,
    20'hc_1000, 20'hd_2000, 20'he_4000, 20'hf_8000};
  ompc_top dut_u (.*);
  ompc_ext_mem mem_u (.*);
  initial
  begin
    forever #2.5 aclk = ~aclk;
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [7:0] d, input logic [15:0] a = OMPC_CTRL_ADDR);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rd_r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [15:0] a = OMPC_CTRL_ADDR);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd_d = s_axi_rdata;
    rd_r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    #1;
  endtask
  task rst(input logic b, input logic a, input logic [7:0] e);
    @(posedge aclk);
    aresetn <= 1'b0;
    mode_pin_b <= b;
    mode_pin_a <= a;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd();
    chk("reset reg", {24'h0, e}, rd_d);
    chk("vector", b ? 16'hfffa : 16'hbffa, reset_vector_addr);
    chk("special", !b, special_mode);
    chk("mode a", a, expanded_mode);
  endtask
  task pulse;
    @(posedge aclk);
    arb_start <= 1'b1;
    @(posedge aclk);
    arb_start <= 1'b0;
    @(posedge aclk);
    #1;
  endtask
  task cyc(input logic w, input logic ph, input logic in);
    @(posedge aclk);
    cpu_cycle <= 1'b1;
    cpu_write <= w;
    cpu_addr_phase <= ph;
    cpu_internal <= in;
    repeat (2) @(posedge aclk);
    #1;
  endtask
  initial
  begin
    rst(1'b0, 1'b1, 8'h76);
    for (int i = 0; i < 16; i++)
    begin
      wr({4'h7, rows[i][19:16]});
      pulse();
      chk("promoted", {16'h0, rows[i][15:0]}, {16'h0, irq_promoted});
    end
    wr(8'h73);
    chk("held", 16'h8000, irq_promoted);
    pulse();
    chk("next arb", 16'h0008, irq_promoted);
    @(posedge aclk);
    irq_src_pending <= 16'hfff7;
    @(posedge aclk);
    #1;
    chk("not pending", 16'h0000, irq_promoted);
    rd(16'h1040);
    chk("unmapped data", 32'h0, rd_d);
    chk("unmapped resp", 2'h2, rd_r);
    wr(8'h00, 16'h1040);
    chk("unmapped wr resp", 2'h2, rd_r);
    @(posedge aclk);
    cpu_addr <= 16'h2012;
    cpu_internal_rdata <= 8'h5c;
    cpu_wdata <= 8'h3e;
    cyc(1'b0, 1'b1, 1'b0);
    chk("addr high", 8'h20, port_b_out);
    chk("addr low", 8'h12, port_c_out);
    chk("addr strobe", 1'b1, address_strobe_out);
    cyc(1'b0, 1'b0, 1'b0);
    chk("ext data", 8'hed, port_c_rdata);
    chk("dir read", 1'b1, strobe_b_output);
    cyc(1'b0, 1'b0, 1'b1);
    chk("visible", 8'h5c, port_c_out);
    chk("visible oe", 8'hff, port_c_oe);
    cyc(1'b1, 1'b0, 1'b0);
    chk("dir write", 1'b0, strobe_b_output);
    chk("wdata", 8'h3e, port_c_out);
    @(posedge aclk);
    cpu_cycle <= 1'b0;
    wr(8'hf6);
    chk("boot on", 1'b1, boot_rom_mapped);
    chk("wr resp", 2'h0, rd_r);
    wr(8'hb6);
    chk("boot off", 1'b0, boot_rom_mapped);
    chk("normal vec", 16'hfffa, reset_vector_addr);
    wr(8'hf6);
    chk("special stays", 1'b0, special_mode);
    rst(1'b0, 1'b0, 8'hc6);
    chk("boot strap", 1'b1, boot_rom_mapped);
    rst(1'b1, 1'b1, 8'h26);
    rst(1'b1, 1'b0, 8'h06);
    @(posedge aclk);
    gp_port_b <= 8'ha5;
    gp_port_c <= 8'h3c;
    gp_port_c_dir <= 8'h0f;
    strobe_b_level <= 1'b1;
    strobe_a_input <= 1'b1;
    @(posedge aclk);
    #1;
    chk("gp b", 8'ha5, port_b_out);
    chk("gp c", 8'h3c, port_c_out);
    chk("gp dir", 8'h0f, port_c_oe);
    chk("strobe b", 1'b1, strobe_b_output);
    chk("strobe a", 1'b1, strobe_a_handshake);
    chk("strobe b oe", 1'b1, strobe_b_oe);
    wr(8'h26);
    wr(8'h06);
    chk("mode a once", 1'b1, expanded_mode);
    chk("strobe a gated", 1'b0, strobe_a_handshake);
    wr(8'h46);
    wr(8'h86);
    rd();
    chk("normal reg", 32'h26, rd_d);
    test_done();
  end
  initial
  begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    test_done();
  end
endmodule
